// *** shared/iepf_regs.vh ***
// Register offsets, field positions and reset values of the interrupt enable/priority/flag block
`ifndef IEPF_REGS_VH
`define IEPF_REGS_VH

// Register addresses
`define IEPF_ADDR_FLAG 8'h88
`define IEPF_ADDR_PRIO0 8'hB8
`define IEPF_ADDR_EN1 8'hE6
`define IEPF_ADDR_PRIO1 8'hF6
`define IEPF_ADDR_EN0 8'hA8
`define IEPF_ADDR_ISTAT 8'hC0
`define IEPF_ADDR_IMASK 8'hC1

// Flag register fields
`define IEPF_T1_OVF_BIT 7
`define IEPF_T1_RUN_BIT 6
`define IEPF_T0_OVF_BIT 5
`define IEPF_T0_RUN_BIT 4
`define IEPF_EXT1_BIT 3
`define IEPF_EXT0_BIT 1

// First enable register fields
`define IEPF_GLOBAL_BIT 7

// Writable bit masks
`define IEPF_FLAG_MASK 8'hFA
`define IEPF_PRIO0_MASK 8'h2F
`define IEPF_EN0_MASK 8'hAF
`define IEPF_EN1_MASK 8'hFC
`define IEPF_PRIO1_MASK 8'hFC

// Reset value of every register
`define IEPF_RST_VAL 8'h00

// Number of request sources seen by the arbiter
`define IEPF_NUM_SRC 11

`endif

// *** src/iepf_sync.v ***
// Two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module iepf_sync
#(
    parameter WIDTH = 2
)
(
    // Clock and reset
    input wire clk_in,
    input wire rst_in,
    // Data
    input wire [WIDTH-1:0] d_in,
    output reg [WIDTH-1:0] q_out
);

reg [WIDTH-1:0] meta_r;

////////////////////////////////////////////////////////////////////////////////
// First stage is read only by the second stage
always @(posedge clk_in or posedge rst_in)
begin
    if (rst_in)
    begin
        meta_r <= {WIDTH{1'b0}};
        q_out <= {WIDTH{1'b0}};
    end
    else
    begin
        meta_r <= d_in;
        q_out <= meta_r;
    end
end

endmodule

// *** src/iepf_ctrl.v ***
// Interrupt enable, priority and flag registers with request arbitration
//
// How it works
// - Priority reg 0xB8, bits 3..0, reset zero
// - Bit 5 of 0xB8 selects timer2 priority
// - Timer1 or mode-3 high-byte overflow sets bit7
// - Bit 6 runs timer1, or high byte in mode3
// - Timer0 overflow sets flag bit 5
// - External request 1 sets bit 3, software clears
// - External request 0 sets bit 1, software clears
// - Flag reg 0x88, bit 4 runs timer0
// - Enable reg 0xE6, bits 7..2, reset zero
// - Second priority reg at 0xF6
// - Second priority bits 7..2 per source
// - Global enable zero masks every arbitrated request; irq_out is not gated
// - High priority first, then lower position
`timescale 1ns/1ps
`include "iepf_regs.vh"
module iepf_ctrl
#(
    parameter NSRC = `IEPF_NUM_SRC
)
(
    // Clock and reset
    input wire core_clk_in,
    input wire sys_rst_in,
    // Register port
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [7:0] reg_rdata_out,
    // Timer side, same clock
    input wire timer1_ovf_in,
    input wire timer0_ovf_in,
    input wire timer0_high_byte_ovf_in,
    input wire timer0_mode3_in,
    output reg timer1_run_out,
    output reg timer0_run_out,
    output reg timer0_high_byte_run_out,
    // External request pins
    input wire external_request_1_in,
    input wire external_request_0_in,
    // Peripheral request levels, bit 0 up: timer2, wdt/t2, spi, touch, adc, ext3, ext2
    input wire [6:0] periph_req_in,
    // CPU side
    output reg cpu_irq_out,
    output reg cpu_irq_high_out,
    output reg [3:0] cpu_irq_id_out,
    // Event interrupt
    output reg irq_out
);

// Source index order (natural priority, lowest wins):
// 0 ext0, 1 timer0, 2 ext1, 3 timer1, 4 timer2, 5 ext2, 6 ext3,
// 7 adc, 8 touch, 9 spi, 10 wdt/t2
// Peripheral levels are not latched here: their sticky flags live in
// the peripherals, so a request drops as soon as its level drops.

////////////////////////////////////////////////////////////////////////////////
// Registers and wires
reg [7:0] flag_r;
reg [7:0] prio0_r;
reg [7:0] en0_r;
reg [7:0] en1_r;
reg [7:0] prio1_r;
reg [7:0] istat_r;
reg [7:0] imask_r;
reg [1:0] ext_d_r;
// Next values and arbiter results, all combinational
reg [7:0] flag_nxt;
reg [7:0] istat_nxt;
reg [7:0] rdata_nxt;
reg [NSRC-1:0] pend;
reg [NSRC-1:0] ena;
reg [NSRC-1:0] hi;
reg found;
reg found_hi;
reg [3:0] win_id;
reg irq_nxt;
integer i;
wire [1:0] ext_s;
wire ext1_rise;
wire ext0_rise;
wire wr_flag;
wire t1_evt;
wire [7:0] evt;

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers; edges are taken on the synchronised copy only
// Pins are expected idle low; one held high across reset shows an edge
// after release and sets its flag, which software then clears.
iepf_sync #(.WIDTH(2)) u_sync
(
    .clk_in(core_clk_in),
    .rst_in(sys_rst_in),
    .d_in({external_request_1_in, external_request_0_in}),
    .q_out(ext_s)
);

// Rising edge detectors on the synchronised requests
assign ext1_rise = ext_s[1] & ~ext_d_r[1];
assign ext0_rise = ext_s[0] & ~ext_d_r[0];
// Flag register write decode, shared with the next-value logic
assign wr_flag = reg_wr_in && (reg_addr_in == `IEPF_ADDR_FLAG);

// In mode 3 the high byte borrows the timer1 flag
// Timer1 overflow sources
assign t1_evt = timer1_ovf_in | (timer0_mode3_in & timer0_high_byte_ovf_in);

// Events that feed the sticky status register
assign evt = {4'h0, ext1_rise, ext0_rise, timer0_ovf_in, t1_evt};

////////////////////////////////////////////////////////////////////////////////
// Flag register next value; hardware set beats software write
always @*
begin
    flag_nxt = flag_r;
    // Reserved bits 2 and 0 are masked so they always read zero; a write
    // may also set a flag, which raises a request like hardware would
    if (wr_flag)
    begin
        flag_nxt = reg_wdata_in & `IEPF_FLAG_MASK;
    end
    if (t1_evt)
    begin
        flag_nxt[`IEPF_T1_OVF_BIT] = 1'b1;
    end
    if (timer0_ovf_in)
    begin
        flag_nxt[`IEPF_T0_OVF_BIT] = 1'b1;
    end
    if (ext1_rise)
    begin
        flag_nxt[`IEPF_EXT1_BIT] = 1'b1;
    end
    if (ext0_rise)
    begin
        flag_nxt[`IEPF_EXT0_BIT] = 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Status register: write one clears, a same-cycle event wins
always @*
begin
    istat_nxt = istat_r;
    if (reg_wr_in && (reg_addr_in == `IEPF_ADDR_ISTAT))
    begin
        istat_nxt = istat_r & ~reg_wdata_in;
    end
    // Bits 7..4 have no event behind them and stay zero
    istat_nxt = istat_nxt | evt;
end

////////////////////////////////////////////////////////////////////////////////
// Register writes and state update
always @(posedge core_clk_in or posedge sys_rst_in)
begin
    if (sys_rst_in)
    begin
        flag_r <= `IEPF_RST_VAL;
        prio0_r <= `IEPF_RST_VAL;
        en0_r <= `IEPF_RST_VAL;
        en1_r <= `IEPF_RST_VAL;
        prio1_r <= `IEPF_RST_VAL;
        istat_r <= `IEPF_RST_VAL;
        imask_r <= `IEPF_RST_VAL;
        ext_d_r <= 2'h0;
    end
    else
    begin
        flag_r <= flag_nxt;
        istat_r <= istat_nxt;
        ext_d_r <= ext_s;
        // Writes to unmapped addresses fall through and are dropped
        if (reg_wr_in)
        begin
            if (reg_addr_in == `IEPF_ADDR_PRIO0)
            begin
                prio0_r <= reg_wdata_in & `IEPF_PRIO0_MASK;
            end
            // First group; bit 7 is the global enable
            else if (reg_addr_in == `IEPF_ADDR_EN0)
            begin
                en0_r <= reg_wdata_in & `IEPF_EN0_MASK;
            end
            else if (reg_addr_in == `IEPF_ADDR_EN1)
            begin
                en1_r <= reg_wdata_in & `IEPF_EN1_MASK;
            end
            else if (reg_addr_in == `IEPF_ADDR_PRIO1)
            begin
                prio1_r <= reg_wdata_in & `IEPF_PRIO1_MASK;
            end
            else if (reg_addr_in == `IEPF_ADDR_IMASK)
            begin
                imask_r <= reg_wdata_in;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read mux; unmapped addresses read zero
// Reads have no side effects; flags clear only by a write
always @*
begin
    rdata_nxt = 8'h00;
    if (reg_addr_in == `IEPF_ADDR_FLAG)
    begin
        rdata_nxt = flag_r;
    end
    else if (reg_addr_in == `IEPF_ADDR_PRIO0)
    begin
        rdata_nxt = prio0_r;
    end
    else if (reg_addr_in == `IEPF_ADDR_EN0)
    begin
        rdata_nxt = en0_r;
    end
    else if (reg_addr_in == `IEPF_ADDR_EN1)
    begin
        rdata_nxt = en1_r;
    end
    else if (reg_addr_in == `IEPF_ADDR_PRIO1)
    begin
        rdata_nxt = prio1_r;
    end
    else if (reg_addr_in == `IEPF_ADDR_ISTAT)
    begin
        rdata_nxt = istat_r;
    end
    else if (reg_addr_in == `IEPF_ADDR_IMASK)
    begin
        rdata_nxt = imask_r;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Source vectors for the arbiter
always @*
begin
    // Timer2 is reported on bit 0 of the peripheral vector
    pend = {periph_req_in[1], periph_req_in[2], periph_req_in[3], periph_req_in[4],
            periph_req_in[5], periph_req_in[6], periph_req_in[0],
            flag_r[`IEPF_T1_OVF_BIT], flag_r[`IEPF_EXT1_BIT],
            flag_r[`IEPF_T0_OVF_BIT], flag_r[`IEPF_EXT0_BIT]};
    // Second group on top, then timer2 and the first group
    ena = {en1_r[7], en1_r[6], en1_r[5], en1_r[4], en1_r[3], en1_r[2],
           en0_r[5], en0_r[3], en0_r[2], en0_r[1], en0_r[0]};
    hi = {prio1_r[7], prio1_r[6], prio1_r[5], prio1_r[4], prio1_r[3], prio1_r[2],
          prio0_r[5], prio0_r[3], prio0_r[2], prio0_r[1], prio0_r[0]};
end

////////////////////////////////////////////////////////////////////////////////
// Arbiter: a loop from the top so the lowest index is written last
// Two scans cost a few more gates than a priority tree but are easy to
// follow, and eleven sources keep the logic depth small at this clock
always @*
begin
    found = 1'b0;
    found_hi = 1'b0;
    win_id = 4'h0;
    // Low priority pass, lowest position wins
    for (i = NSRC - 1; i >= 0; i = i - 1)
    begin
        if (pend[i] && ena[i] && !hi[i])
        begin
            found = 1'b1;
            win_id = i[3:0];
        end
    end
    for (i = NSRC - 1; i >= 0; i = i - 1)
    begin
        if (pend[i] && ena[i] && hi[i])
        begin
            found = 1'b1;
            found_hi = 1'b1;
            win_id = i[3:0];
        end
    end
    if (!en0_r[`IEPF_GLOBAL_BIT])
    begin
        found = 1'b0;
        found_hi = 1'b0;
        win_id = 4'h0;
    end
end

// Event interrupt level from masked sticky bits
// Using the next status lets the line rise with the flag, not after it
always @*
begin
    irq_nxt = |(istat_nxt & imask_r);
end

////////////////////////////////////////////////////////////////////////////////
// Registered outputs; run bits and irq_out come from next values and change with the state
always @(posedge core_clk_in or posedge sys_rst_in)
begin
    if (sys_rst_in)
    begin
        reg_rdata_out <= 8'h00;
        timer1_run_out <= 1'b0;
        timer0_run_out <= 1'b0;
        timer0_high_byte_run_out <= 1'b0;
        cpu_irq_out <= 1'b0;
        cpu_irq_high_out <= 1'b0;
        cpu_irq_id_out <= 4'h0;
        irq_out <= 1'b0;
    end
    else
    begin
        // Read data stand one cycle and are zero otherwise, so a stale
        // value can never be taken for a fresh answer
        reg_rdata_out <= reg_rd_in ? rdata_nxt : 8'h00;
        // Run bit steers timer1 or high byte
        timer1_run_out <= flag_nxt[`IEPF_T1_RUN_BIT] & ~timer0_mode3_in;
        timer0_high_byte_run_out <= flag_nxt[`IEPF_T1_RUN_BIT] & timer0_mode3_in;
        timer0_run_out <= flag_nxt[`IEPF_T0_RUN_BIT];
        // Request, level and winner to the core
        cpu_irq_out <= found;
        cpu_irq_high_out <= found_hi;
        cpu_irq_id_out <= win_id;
        // Sticky event line
        irq_out <= irq_nxt;
    end
end

endmodule

// *** tb/iepf_timer_model.sv ***
// Timer pair model: overflow pulses every eight cycles while running
`timescale 1ns/1ps
module iepf_timer_model
(
    // Clock and reset
    input wire clk_in,
    input wire rst_in,
    // Run levels in, overflow pulses out
    input wire t1_run_in,
    input wire t0_run_in,
    input wire hb_run_in,
    output reg t1_ovf_out,
    output reg t0_ovf_out,
    output reg hb_ovf_out
);
    reg [2:0] cnt_r;
    // Eight-cycle wrap instead of 256 keeps the run short
    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            {cnt_r, t1_ovf_out, t0_ovf_out, hb_ovf_out} <= 6'h00;
        else
        begin
            cnt_r <= cnt_r + 3'h1;
            t1_ovf_out <= t1_run_in && cnt_r == 3'h7;
            t0_ovf_out <= t0_run_in && cnt_r == 3'h7;
            hb_ovf_out <= hb_run_in && cnt_r == 3'h7;
        end
    end
endmodule

// *** tb/iepf_properties.sv ***
// Assertion checker for the interrupt enable, priority and flag block
`timescale 1ns/1ps
module iepf_properties
#(
    parameter NSRC = 11
)
(
    // Clock, reset, register port
    input wire core_clk_in,
    input wire sys_rst_in,
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [7:0] reg_rdata_out,
    // Timer and CPU side
    input wire timer0_mode3_in,
    input wire timer1_run_out,
    input wire timer0_run_out,
    input wire timer0_high_byte_run_out,
    input wire cpu_irq_out,
    input wire [3:0] cpu_irq_id_out
);
    reg glob_r;
    wire wr88 = reg_wr_in && reg_addr_in == 8'h88;
    wire rd88 = reg_rd_in && reg_addr_in == 8'h88;
    wire rdb8 = reg_rd_in && reg_addr_in == 8'hB8;
    wire rde6 = reg_rd_in && reg_addr_in == 8'hE6;
    wire rdf6 = reg_rd_in && reg_addr_in == 8'hF6;
    default clocking dc @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    // Shadow of the global enable, so masking is judged from the bus alone
    always @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            glob_r <= 1'b0;
        else if (reg_wr_in && reg_addr_in == 8'hA8)
            glob_r <= reg_wdata_in[7];
    end
    ////////////////////////////////////////////////////////////////
    a_run0_write: assert property (wr88 |=> timer0_run_out == $past(reg_wdata_in[4]))
        else $error("timer0 run bad");
    a_run1_mode: assert property (wr88 |=> timer1_run_out == ($past(reg_wdata_in[6]) && !$past(timer0_mode3_in)))
        else $error("timer1 run bad");
    a_run_exclusive: assert property (!(timer1_run_out && timer0_high_byte_run_out))
        else $error("both runs high");
    a_flag_rsvd: assert property (rd88 |=> reg_rdata_out[2] == 1'b0 && reg_rdata_out[0] == 1'b0)
        else $error("flag reserved bits set");
    a_prio_rsvd: assert property (rdb8 |=> reg_rdata_out[7:6] == 2'h0 && !reg_rdata_out[4])
        else $error("priority reserved bits set");
    a_en1_rsvd: assert property (rde6 |=> reg_rdata_out[1:0] == 2'h0)
        else $error("enable reserved bits set");
    a_global_mask: assert property (!glob_r && !$past(glob_r) |-> !cpu_irq_out)
        else $error("request while global off");
    a_id_range: assert property (cpu_irq_out |-> cpu_irq_id_out <= NSRC - 1)
        else $error("winner index out of range");
    a_hb_run_mode: assert property (wr88 |=> timer0_high_byte_run_out ==
        ($past(reg_wdata_in[6]) && $past(timer0_mode3_in)))
        else $error("high byte run bad");
    a_prio1_rsvd: assert property (rdf6 |=> reg_rdata_out[1:0] == 2'h0)
        else $error("second priority reserved bits set");
endmodule

bind iepf_ctrl iepf_properties #(.NSRC(NSRC)) u_props (.core_clk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .timer0_mode3_in, .timer1_run_out, .timer0_run_out,
    .timer0_high_byte_run_out, .cpu_irq_out, .cpu_irq_id_out);

// *** tb/testbench.sv ***
// Self-checking bench for the interrupt enable, priority and flag block
`timescale 1ns/1ps
module testbench;
    reg clk, rst, wr, rd, mode3, ext1, ext0;
    reg [7:0] addr, wdata;
    reg [6:0] preq;
    reg [15:0] seed, s1;
    wire [7:0] rdata;
    wire ovf1, ovf0, ovfh, run1, run0, runh, irq_any, irq_hi, irq;
    wire [3:0] irq_id;
    integer err_count, comparisons, i;
    iepf_ctrl uut (.core_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .timer1_ovf_in(ovf1), .timer0_ovf_in(ovf0),
        .timer0_high_byte_ovf_in(ovfh), .timer0_mode3_in(mode3), .timer1_run_out(run1), .timer0_run_out(run0),
        .timer0_high_byte_run_out(runh), .external_request_1_in(ext1), .external_request_0_in(ext0),
        .periph_req_in(preq), .cpu_irq_out(irq_any), .cpu_irq_high_out(irq_hi), .cpu_irq_id_out(irq_id),
        .irq_out(irq));
    iepf_timer_model tmr (.clk_in(clk), .rst_in(rst), .t1_run_in(run1), .t0_run_in(run0), .hb_run_in(runh),
        .t1_ovf_out(ovf1), .t0_ovf_out(ovf0), .hb_ovf_out(ovfh));
    ////////////////////////////////////////////////////////////////
    function [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Random target, one of them unmapped so a refused write is exercised
    function [7:0] pick(input [1:0] k);
        pick = (k == 2'd0) ? 8'hB8 : (k == 2'd1) ? 8'hE6 : (k == 2'd2) ? 8'hF6 : 8'h55;
    endfunction
    function [7:0] wmask(input [7:0] a);
        wmask = (a == 8'hB8) ? 8'h2F : (a == 8'hE6 || a == 8'hF6) ? 8'hFC : 8'h00;
    endfunction
    // Expected winner among timer2 and the second group: a high request
    // first, then the lowest position; the first group is left disabled
    function [7:0] arb(input [6:0] p, input [7:0] e1, input [7:0] p1, input t2hi);
        reg [10:4] pn, en, hh;
        reg f, fh;
        reg [3:0] id;
        integer k;
    begin
        f = 1'b0;
        fh = 1'b0;
        id = 4'h0;
        pn = {p[1], p[2], p[3], p[4], p[5], p[6], p[0]};
        en = {e1[7:2], 1'b1};
        hh = {p1[7:2], t2hi};
        for (k = 4; k <= 10; k = k + 1)
        begin
            if (pn[k] && en[k] && hh[k] && !fh)
            begin
                fh = 1'b1;
                id = k[3:0];
            end
        end
        for (k = 4; k <= 10; k = k + 1)
        begin
            if (pn[k] && en[k] && !fh && !f)
            begin
                f = 1'b1;
                id = k[3:0];
            end
        end
        arb = {2'h0, f | fh, fh, id};
    end
    endfunction
    task ck(input [7:0] got, input [7:0] exp);
    begin
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task wt(input integer n);
    begin
        repeat (n) @(posedge clk);
        #1;
    end
    endtask
    task wreg(input [7:0] a, input [7:0] d);
    begin
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    end
    endtask
    // Read data stand only in the cycle after the strobe
    task rreg(input [7:0] a, input [7:0] exp);
    begin
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 ck(rdata, exp);
    end
    endtask
    task wrap_up;
    begin
        $display("errors %0d of %0d checks", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Hang guard
    initial
    begin
        #100000;
        err_count = err_count + 1;
        wrap_up;
    end
    initial
    begin
        {rst, wr, rd, mode3, ext1, ext0} = 6'h20;
        {addr, wdata, preq} = 23'h0;
        seed = 16'hF0F0;
        err_count = 0;
        comparisons = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rreg(8'h88, 8'h00);
        rreg(8'hB8, 8'h00);
        rreg(8'hE6, 8'h00);
        rreg(8'hF6, 8'h00);
        for (i = 0; i < 16; i = i + 1)
        begin
            seed = lfsr(seed);
            wreg(pick(seed[9:8]), seed[7:0]);
            rreg(pick(seed[9:8]), seed[7:0] & wmask(pick(seed[9:8])));
        end
        wreg(8'hB8, 8'h00);
        wreg(8'hF6, 8'h00);
        // Both timers running raise both overflow flags
        wreg(8'h88, 8'h50);
        wt(1);
        ck({6'h00, run1, run0}, 8'h03);
        wt(20);
        rreg(8'h88, 8'hF0);
        // Stop twice: a late overflow pulse may win over the first clear
        wreg(8'h88, 8'h00);
        wreg(8'h88, 8'h00);
        mode3 <= 1'b1;
        wreg(8'h88, 8'h40);
        wt(1);
        ck({6'h00, run1, runh}, 8'h01);
        wt(20);
        rreg(8'h88, 8'hC0);
        wreg(8'h88, 8'h00);
        mode3 <= 1'b0;
        wreg(8'h88, 8'h00);
        // Two pins plus an SPI level request, arbitrated
        wreg(8'hA8, 8'h85);
        wreg(8'hE6, 8'h40);
        preq <= 7'h04;
        ext0 <= 1'b1;
        ext1 <= 1'b1;
        wt(6);
        rreg(8'h88, 8'h0A);
        ck({2'h0, irq_any, irq_hi, irq_id}, 8'h20);
        wreg(8'hF6, 8'h40);
        wt(2);
        ck({2'h0, irq_any, irq_hi, irq_id}, 8'h39);
        wreg(8'hB8, 8'h04);
        wt(2);
        ck({2'h0, irq_any, irq_hi, irq_id}, 8'h32);
        wreg(8'hA8, 8'h05);
        wt(2);
        ck({7'h00, irq_any}, 8'h00);
        wreg(8'hE6, 8'h00);
        wreg(8'hA8, 8'h80);
        wt(2);
        ck({7'h00, irq_any}, 8'h00);
        wreg(8'h88, 8'h00);
        rreg(8'h88, 8'h00);
        // Event status: masked, unmasked, then cleared by writing one
        ck({7'h00, irq}, 8'h00);
        wreg(8'hC1, 8'h04);
        wt(2);
        ck({7'h00, irq}, 8'h01);
        wreg(8'hC0, 8'h04);
        wt(2);
        ck({7'h00, irq}, 8'h00);
        // Random peripheral levels against the second group and timer2
        wreg(8'hA8, 8'hA0);
        ext0 <= 1'b0;
        ext1 <= 1'b0;
        for (i = 0; i < 12; i = i + 1)
        begin
            repeat (8) seed = lfsr(seed);
            s1 = seed;
            wreg(8'hE6, s1[7:0]);
            wreg(8'hF6, s1[15:8]);
            repeat (8) seed = lfsr(seed);
            wreg(8'hB8, {2'h0, seed[9], 5'h00});
            preq <= seed[6:0];
            wt(3);
            ck({2'h0, irq_any, irq_hi, irq_id}, arb(seed[6:0], s1[7:0], s1[15:8], seed[9]));
        end
        // Mid-run reset with both timers running clears everything
        wreg(8'h88, 8'h50);
        preq <= 7'h00;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        wt(1);
        ck({4'h0, run1, run0, runh, irq_any}, 8'h00);
        rreg(8'h88, 8'h00);
        rreg(8'hE6, 8'h00);
        rreg(8'hF6, 8'h00);
        wrap_up;
    end
endmodule
